// ===== pmc_pkg.sv
// Shared constants, mode encodings and carrier types for the port pin mode block.
`default_nettype none
package pmc_pkg;
	// Register indices; the byte address on the bus is four times the index.
	localparam logic [7:0] IDX_P2_LOW  = 8'hb1;
	localparam logic [7:0] IDX_P2_HIGH = 8'hb2;
	localparam logic [7:0] IDX_P3_LOW  = 8'hb3;
	localparam logic [7:0] IDX_P3_HIGH = 8'hb4;
	localparam logic [7:0] IDX_MEM_CTL = 8'hb8;
	localparam logic [7:0] IDX_STATUS  = 8'hb9;
	// Reset values of the writable registers.
	localparam logic [7:0] RST_P2_LOW  = 8'h00;
	localparam logic [7:0] RST_P2_HIGH = 8'h00;
	localparam logic [7:0] RST_P3_LOW  = 8'h00;
	localparam logic [7:0] RST_P3_HIGH = 8'h00;
	localparam logic [7:0] RST_MEM_CTL = 8'h00;
	// Memory access control bit that hands the second port to the memory bus.
	localparam int unsigned MEM_CTL_EXT_BIT = 1;
	// Status bit positions.
	localparam int unsigned STAT_EXT_BIT = 0;
	localparam int unsigned STAT_PIN_BIT = 1;
	// Third-port pins that carry the read and write strobes.
	localparam int unsigned P3_RD_PIN = 7;
	localparam int unsigned P3_WR_PIN = 6;
	// Width of one pin mode field.
	localparam int unsigned FIELD_W = 2;
	// Pin output modes.
	typedef enum logic [1:0]
	{
		MODE_QUASI = 2'b00,
		MODE_PUSH  = 2'b01,
		MODE_OPEN  = 2'b10,
		MODE_INPUT = 2'b11
	} pmc_mode_t;
	// Drive of one eight-pin port: level and output enable per pin.
	typedef struct packed
	{
		logic [7:0] level;
		logic [7:0] enable;
	} pmc_drive_t;
endpackage
`default_nettype wire

// ===== pmc_port_mode.sv
// Pin mode registers and pin drivers for the second and third ports.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Two-bit field per pin selects its mode
// - Second port low register: pins 3 to 0
// - Second port high register at B2
// - Third port low register at B3, resets zero
// - Third port high register at B4, resets zero
// - External memory overrides second port fields
module pmc_port_mode #(
	parameter int unsigned ADDR_W = 12
)(
	// Clock and reset.
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	// APB slave.
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// External memory enable pin, low selects external memory.
	input  wire logic              extMemEnablePinN,
	// Core port data and memory bus signals.
	input  wire logic [7:0]        port2Data,
	input  wire logic [7:0]        port3Data,
	input  wire logic [7:0]        memAddrHigh,
	input  wire logic              memReadStrobeN,
	input  wire logic              memWriteStrobeN,
	// Pin drives.
	output pmc_pkg::pmc_drive_t    port2Drive,
	output pmc_pkg::pmc_drive_t    port3Drive
);
	// Register file.
	logic [7:0] p2Low_r,   p2Low_nxt;
	logic [7:0] p2High_r,  p2High_nxt;
	logic [7:0] p3Low_r,   p3Low_nxt;
	logic [7:0] p3High_r,  p3High_nxt;
	logic [7:0] memCtl_r,  memCtl_nxt;
	// Bus answer registers.
	logic [31:0] rdData_r, rdData_nxt;
	logic        slvErr_r, slvErr_nxt;
	// Pin state.
	logic [7:0]  p2Prev_r, p3Prev_r;
	pmc_pkg::pmc_drive_t p2Drv_r, p2Drv_nxt;
	pmc_pkg::pmc_drive_t p3Drv_r, p3Drv_nxt;
	// Decoded access signals.
	logic       setup;
	logic       wrAcc;
	logic       extMem;

	// Returns true when the byte address hits the given register index.
	function automatic logic regHit(input logic [ADDR_W-1:0] a, input logic [7:0] i);
		regHit = (a == ADDR_W'({i, 2'b00}));
	endfunction

	// Maps a mode, data bit and rising flag to {level, enable}.
	function automatic logic [1:0] pinDrive(input logic [1:0] mode, input logic d, input logic rise);
		logic [1:0] r;
		r = 2'b00;
		case (pmc_pkg::pmc_mode_t'(mode))
			// Quasi mode sinks low and kicks high for one cycle on a rise.
			pmc_pkg::MODE_QUASI: r = {d, ~d | rise};
			pmc_pkg::MODE_PUSH:  r = {d, 1'b1};
			// Open drain only ever pulls low.
			pmc_pkg::MODE_OPEN:  r = {1'b0, ~d};
			pmc_pkg::MODE_INPUT: r = 2'b00;
			default:             r = 2'b00;
		endcase
		pinDrive = r;
	endfunction

	// Phase decode: setup for the read path, wrAcc for the write path.
	assign setup  = psel & ~penable;
	assign wrAcc  = psel & penable & pwrite & pstrb[0];
	// The port goes to the memory bus on the pin or the control bit.
	assign extMem = ~extMemEnablePinN | memCtl_r[pmc_pkg::MEM_CTL_EXT_BIT];

	// Register writes; only byte lane zero carries data.
	always_comb
	begin
		p2Low_nxt  = p2Low_r;
		p2High_nxt = p2High_r;
		p3Low_nxt  = p3Low_r;
		p3High_nxt = p3High_r;
		memCtl_nxt = memCtl_r;
		if (wrAcc)
		begin
			if (regHit(paddr, pmc_pkg::IDX_P2_LOW))
				p2Low_nxt = pwdata[7:0];
			if (regHit(paddr, pmc_pkg::IDX_P2_HIGH))
				p2High_nxt = pwdata[7:0];
			if (regHit(paddr, pmc_pkg::IDX_P3_LOW))
				p3Low_nxt = pwdata[7:0];
			if (regHit(paddr, pmc_pkg::IDX_P3_HIGH))
				p3High_nxt = pwdata[7:0];
			if (regHit(paddr, pmc_pkg::IDX_MEM_CTL))
				memCtl_nxt = pwdata[7:0];
		end
	end

	// Register state.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			p2Low_r  <= pmc_pkg::RST_P2_LOW;
			p2High_r <= pmc_pkg::RST_P2_HIGH;
			p3Low_r  <= pmc_pkg::RST_P3_LOW;
			p3High_r <= pmc_pkg::RST_P3_HIGH;
			memCtl_r <= pmc_pkg::RST_MEM_CTL;
		end
		else
		begin
			p2Low_r  <= p2Low_nxt;
			p2High_r <= p2High_nxt;
			p3Low_r  <= p3Low_nxt;
			p3High_r <= p3High_nxt;
			memCtl_r <= memCtl_nxt;
		end
	end

	// Read data and error are captured in the setup cycle.
	always_comb
	begin
		rdData_nxt = rdData_r;
		slvErr_nxt = 1'b0;
		if (setup)
		begin
			rdData_nxt = 32'h0000_0000;
			if (regHit(paddr, pmc_pkg::IDX_P2_LOW))
				rdData_nxt[7:0] = p2Low_r;
			else if (regHit(paddr, pmc_pkg::IDX_P2_HIGH))
				rdData_nxt[7:0] = p2High_r;
			else if (regHit(paddr, pmc_pkg::IDX_P3_LOW))
				rdData_nxt[7:0] = p3Low_r;
			else if (regHit(paddr, pmc_pkg::IDX_P3_HIGH))
				rdData_nxt[7:0] = p3High_r;
			else if (regHit(paddr, pmc_pkg::IDX_MEM_CTL))
				rdData_nxt[7:0] = memCtl_r;
			else if (regHit(paddr, pmc_pkg::IDX_STATUS))
			begin
				// Status is read-only; a write to it is refused.
				rdData_nxt[pmc_pkg::STAT_EXT_BIT] = extMem;
				rdData_nxt[pmc_pkg::STAT_PIN_BIT] = extMemEnablePinN;
				slvErr_nxt = pwrite;
			end
			else
				slvErr_nxt = 1'b1;
		end
	end

	// Bus answer registers.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			rdData_r <= 32'h0000_0000;
			slvErr_r <= 1'b0;
		end
		else
		begin
			rdData_r <= rdData_nxt;
			slvErr_r <= slvErr_nxt;
		end
	end

	// Access phase always completes at once.
	assign pready  = 1'b1;
	assign prdata  = rdData_r;
	assign pslverr = slvErr_r & psel & penable;

	// Per-pin drive from the mode fields and the memory overrides.
	always_comb
	begin
		logic [15:0] p2Modes;
		logic [15:0] p3Modes;
		logic [1:0]  d;
		p2Modes = {p2High_r, p2Low_r};
		p3Modes = {p3High_r, p3Low_r};
		p2Drv_nxt = '0;
		p3Drv_nxt = '0;
		d = 2'b00;
		for (int i = 0; i < 8; i++)
		begin
			d = pinDrive(p2Modes[i*pmc_pkg::FIELD_W +: 2], port2Data[i],
				port2Data[i] & ~p2Prev_r[i]);
			p2Drv_nxt.level[i]  = d[1];
			p2Drv_nxt.enable[i] = d[0];
			d = pinDrive(p3Modes[i*pmc_pkg::FIELD_W +: 2], port3Data[i],
				port3Data[i] & ~p3Prev_r[i]);
			p3Drv_nxt.level[i]  = d[1];
			p3Drv_nxt.enable[i] = d[0];
		end
		if (extMem)
		begin
			// The high address byte takes the whole second port.
			p2Drv_nxt.level  = memAddrHigh;
			p2Drv_nxt.enable = 8'hff;
			// Strobes drive the two top pins of the third port.
			p3Drv_nxt.level[pmc_pkg::P3_RD_PIN]  = memReadStrobeN;
			p3Drv_nxt.enable[pmc_pkg::P3_RD_PIN] = 1'b1;
			p3Drv_nxt.level[pmc_pkg::P3_WR_PIN]  = memWriteStrobeN;
			p3Drv_nxt.enable[pmc_pkg::P3_WR_PIN] = 1'b1;
		end
	end

	// Pin drive registers; all pins float during reset.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			p2Drv_r  <= '0;
			p3Drv_r  <= '0;
			p2Prev_r <= 8'h00;
			p3Prev_r <= 8'h00;
		end
		else
		begin
			p2Drv_r  <= p2Drv_nxt;
			p3Drv_r  <= p3Drv_nxt;
			p2Prev_r <= port2Data;
			p3Prev_r <= port3Data;
		end
	end

	assign port2Drive = p2Drv_r;
	assign port3Drive = p3Drv_r;

	// Checks.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	// A completed write of byte lane zero to one index.
	sequence wrDone(logic [7:0] i);
		psel && penable && pwrite && pready && pstrb[0] && regHit(paddr, i);
	endsequence

	chk_push_pull_drive: assert property (
		(p3Low_r[1:0] == 2'b01 && !extMem) |=> port3Drive.enable[0] && port3Drive.level[0] == $past(port3Data[0]))
		else $error("push-pull pin not driven");
	chk_input_mode_float: assert property (
		(p3Low_r[3:2] == 2'b11 && !extMem) |=> !port3Drive.enable[1])
		else $error("input pin driven");
	chk_p2_low_field: assert property (
		wrDone(pmc_pkg::IDX_P2_LOW) ##1 (!extMem && !penable)
		|=> port2Drive.enable[1] == (p2Low_r[3:2] == 2'b01 || (p2Low_r[3:2] != 2'b11 && !$past(port2Data[1]))
		|| (p2Low_r[3:2] == 2'b00 && $past(port2Data[1]) && !$past(p2Prev_r[1]))))
		else $error("second port pin 1 drive wrong");
	chk_p2_high_write: assert property (
		wrDone(pmc_pkg::IDX_P2_HIGH) |=> p2High_r[7:6] == $past(pwdata[7:6]))
		else $error("second port high register not written");
	chk_p3_low_write: assert property (
		wrDone(pmc_pkg::IDX_P3_LOW) |=> p3Low_r == $past(pwdata[7:0]))
		else $error("third port low register not written");
	chk_p3_high_read: assert property (
		psel && !penable && !pwrite && regHit(paddr, pmc_pkg::IDX_P3_HIGH)
		|=> prdata == {24'h000000, p3High_r})
		else $error("third port high readback wrong");
	chk_p2_override: assert property (
		extMem |=> port2Drive.enable == 8'hff && port2Drive.level == $past(memAddrHigh))
		else $error("second port not overridden");
	chk_p3_strobes: assert property (
		extMem |=> port3Drive.enable[7:6] == 2'b11
		&& port3Drive.level[7:6] == {$past(memReadStrobeN), $past(memWriteStrobeN)})
		else $error("third port strobes not overridden");
endmodule
`default_nettype wire

// ===== port_pin_mode_config_test.sv
// Self-checking bench for the port pin mode block.
`timescale 1ns/1ns
`default_nettype none
module port_pin_mode_config_test;
	// Bench drives, design outputs and bookkeeping.
	logic                clk_sys = 1'b0;
	logic                resetn = 1'b0;
	logic [11:0]         paddr = 12'h000;
	logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [31:0]         pwdata = 32'h0, prdata, rd;
	logic [3:0]          pstrb = 4'hf;
	logic                extPinN = 1'b1, rdStbN = 1'b1, wrStbN = 1'b1, er, ext;
	logic [7:0]          p2Data = 8'h00, p3Data = 8'h00, addrHigh = 8'h00;
	pmc_pkg::pmc_drive_t p2Drive, p3Drive, e2, e3;
	logic [7:0]          regVal [4];
	logic [11:0]         regAddr [4] = '{12'h2c4, 12'h2c8, 12'h2cc, 12'h2d0};
	int                  mismatches = 0, comparisons = 0, seed = 9;

	pmc_port_mode uut (.clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.extMemEnablePinN(extPinN), .port2Data(p2Data), .port3Data(p3Data), .memAddrHigh(addrHigh),
		.memReadStrobeN(rdStbN), .memWriteStrobeN(wrStbN), .port2Drive(p2Drive), .port3Drive(p3Drive));

	// The clock toggles every half period of 10 ns.
	initial forever #10 clk_sys = ~clk_sys;

	// One APB transfer; answers are taken at the edge that samples pready high.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	// Compares two values and counts the outcome.
	task automatic cmpv(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Compares a port drive; the level only counts where the pin is driven.
	task automatic cmpd(input pmc_pkg::pmc_drive_t g, input pmc_pkg::pmc_drive_t e);
		cmpv({16'h0, g.level & g.enable, g.enable}, {16'h0, e.level, e.enable});
	endtask

	// Works out the settled drive of eight pins from their mode fields and data.
	function automatic pmc_pkg::pmc_drive_t expDrive(input logic [15:0] m, input logic [7:0] d);
		pmc_pkg::pmc_drive_t e;
		for (int i = 0; i < 8; i++)
		begin
			e.level[i] = (m[2*i+:2] == 2'b01) & d[i];
			e.enable[i] = (m[2*i+:2] == 2'b01) ? 1'b1 : (m[2*i+:2] == 2'b11) ? 1'b0 : ~d[i];
		end
		return e;
	endfunction

	// Verdict and end of the run.
	task automatic test_done;
		if (mismatches == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// A hang counts as a mismatch.
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		mismatches++;
		test_done;
	end

	// Reset values, an unmapped read, then random modes with and without external memory.
	initial
	begin
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		for (int i = 0; i < 4; i++)
		begin
			xfer(1'b0, regAddr[i], 8'h00);
			cmpv(rd, 32'h0);
		end
		xfer(1'b0, 12'h2d4, 8'h00);
		cmpv({rd[30:0], er}, 32'h1);
		for (int n = 0; n < 24; n++)
		begin
			// The first pass sets all four modes on every register.
			for (int i = 0; i < 4; i++)
			begin
				regVal[i] = (n == 0) ? 8'he4 : 8'($random(seed));
				xfer(1'b1, regAddr[i], regVal[i]);
			end
			for (int i = 0; i < 4; i++)
			begin
				xfer(1'b0, regAddr[i], 8'h00);
				cmpv(rd, {24'h0, regVal[i]});
			end
			// External memory comes first from the pin, later from the control bit.
			if (n == 16)
				extPinN <= 1'b0;
			if (n == 20)
			begin
				extPinN <= 1'b1;
				xfer(1'b1, 12'h2e0, 8'h02);
			end
			ext = (n >= 16);
			p2Data <= 8'($random(seed));
			p3Data <= 8'($random(seed));
			addrHigh <= 8'($random(seed));
			rdStbN <= 1'($random(seed));
			wrStbN <= 1'($random(seed));
			repeat (3) @(posedge clk_sys);
			e2 = ext ? {addrHigh, 8'hff} : expDrive({regVal[1], regVal[0]}, p2Data);
			e3 = expDrive({regVal[3], regVal[2]}, p3Data);
			if (ext)
			begin
				e3.enable[7:6] = 2'b11;
				e3.level[7:6] = {rdStbN, wrStbN};
			end
			cmpd(p2Drive, e2);
			cmpd(p3Drive, e3);
		end
		// Control bit readback, status with the pin high and the control bit set, and a refused status write.
		xfer(1'b0, 12'h2e0, 8'h00);
		cmpv(rd, 32'h2);
		xfer(1'b0, 12'h2e4, 8'h00);
		cmpv({rd[30:0], er}, 32'h6);
		xfer(1'b1, 12'h2e4, 8'h00);
		cmpv({31'h0, er}, 32'h1);
		// A write without byte lane zero leaves the register alone.
		pstrb <= 4'he;
		xfer(1'b1, regAddr[0], ~regVal[0]);
		pstrb <= 4'hf;
		xfer(1'b0, regAddr[0], 8'h00);
		cmpv(rd, {24'h0, regVal[0]});
		// A second reset in mid-run brings the registers back to zero.
		resetn <= 1'b0;
		@(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		xfer(1'b0, regAddr[3], 8'h00);
		cmpv(rd, 32'h0);
		xfer(1'b0, regAddr[2], 8'h00);
		cmpv(rd, 32'h0);
		test_done;
	end
endmodule
`default_nettype wire
